/* design/sfvc_config.sv */
// volatile read and enhanced configuration registers with serial access
`timescale 1ns/1ps
`default_nettype none
module sfvc_config #(
  parameter int VPP_TIMEOUT = sfvc_pkg::VPP_TIMEOUT_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe_out,
  input wire logic [7:0] nv_read_config_in,
  input wire logic [7:0] nv_enhanced_config_in,
  input wire logic basic_xip_variant_in,
  input wire logic vpp_high_in,
  input wire logic quad_modify_done_in,
  input wire logic quad_program_cmd_in,
  input wire logic rd_load_in,
  input wire logic [sfvc_pkg::ADDR_W-1:0] rd_start_addr_in,
  input wire logic rd_advance_in,
  output logic [sfvc_pkg::ADDR_W-1:0] rd_addr_out,
  output sfvc_pkg::sfvc_cfg_t cfg_out,
  output logic accel_speed_out,
  output logic vpp_wait_out,
  output logic vpp_err_out
);
  // ****************************************
  // functions
  // ****************************************
  function automatic logic [2:0] lane_width(input sfvc_pkg::sfvc_proto_t p);
    unique case (p)
      sfvc_pkg::SFVC_PROTO_QUAD: lane_width = 3'h4;
      sfvc_pkg::SFVC_PROTO_DUAL: lane_width = 3'h2;
      default: lane_width = 3'h1;
    endcase
  endfunction : lane_width

  function automatic logic is_read_op(input logic [7:0] op);
    is_read_op = (op == sfvc_pkg::OP_READ_READ_CFG) || (op == sfvc_pkg::OP_READ_ENH_CFG);
  endfunction : is_read_op

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic sck_s1_reg, sck_s2_reg, sck_s3_reg;
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic vpp_s1_reg, vpp_s2_reg;
  logic [3:0] dq_s1_reg, dq_s2_reg;
  logic sck_rise, sck_fall, cs_release, selected;

  // the second and third stages feed edge detection, the first stays isolated
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      vpp_s1_reg <= 1'b0;
      vpp_s2_reg <= 1'b0;
      dq_s1_reg <= 4'h0;
      dq_s2_reg <= 4'h0;
    end else begin
      sck_s1_reg <= sck_in;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      cs_s1_reg <= cs_n_in;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      vpp_s1_reg <= vpp_high_in;
      vpp_s2_reg <= vpp_s1_reg;
      dq_s1_reg <= dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  assign selected = ~cs_s2_reg;
  assign sck_rise = selected & sck_s2_reg & ~sck_s3_reg;
  assign sck_fall = selected & ~sck_s2_reg & sck_s3_reg;
  assign cs_release = cs_s2_reg & ~cs_s3_reg;

  // ****************************************
  // register state and power-on load
  // ****************************************
  logic [7:0] read_cfg_reg;
  logic [7:0] enh_cfg_reg;
  logic load_pend_reg;
  logic basic_xip_reg;
  logic temp_ext_reg;
  logic [7:0] op_reg;
  logic op_valid_reg;
  logic [15:0] in_sh_reg;
  logic [4:0] cnt_reg;
  sfvc_pkg::sfvc_proto_t base_proto;
  sfvc_pkg::sfvc_proto_t eff_proto;
  logic [2:0] lanes;
  logic wr_commit;
  logic frame_long_reg;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      load_pend_reg <= 1'b1;
    end else begin
      load_pend_reg <= 1'b0;
    end
  end

  // straps and nonvolatile values are taken on the first edge after release
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      basic_xip_reg <= 1'b0;
    end else if (load_pend_reg) begin
      basic_xip_reg <= basic_xip_variant_in;
    end
  end

  assign wr_commit = cs_release & op_valid_reg & ~frame_long_reg &
                     (cnt_reg == sfvc_pkg::CNT_FRAME);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      read_cfg_reg <= sfvc_pkg::RC_RESET;
    end else if (load_pend_reg) begin
      read_cfg_reg <= nv_read_config_in & sfvc_pkg::RC_WMASK;
    end else if (wr_commit && op_reg == sfvc_pkg::OP_WRITE_READ_CFG) begin
      read_cfg_reg <= in_sh_reg[7:0] & sfvc_pkg::RC_WMASK;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      enh_cfg_reg <= sfvc_pkg::EC_RESET;
    end else if (load_pend_reg) begin
      enh_cfg_reg <= nv_enhanced_config_in & sfvc_pkg::EC_WMASK;
    end else if (wr_commit && op_reg == sfvc_pkg::OP_WRITE_ENH_CFG) begin
      enh_cfg_reg <= in_sh_reg[7:0] & sfvc_pkg::EC_WMASK;
    end
  end

  // ****************************************
  // protocol selection
  // ****************************************
  always_comb begin
    if (!enh_cfg_reg[sfvc_pkg::EC_QUAD_BIT]) begin
      base_proto = sfvc_pkg::SFVC_PROTO_QUAD;
    end else if (!enh_cfg_reg[sfvc_pkg::EC_DUAL_BIT]) begin
      base_proto = sfvc_pkg::SFVC_PROTO_DUAL;
    end else begin
      base_proto = sfvc_pkg::SFVC_PROTO_EXT;
    end
    eff_proto = temp_ext_reg ? sfvc_pkg::SFVC_PROTO_EXT : base_proto;
    lanes = lane_width(eff_proto);
  end

  // ****************************************
  // serial command capture
  // ****************************************
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      in_sh_reg <= 16'h0000;
      cnt_reg <= 5'h00;
    end else if (!selected) begin
      cnt_reg <= 5'h00;
    end else if (sck_rise && cnt_reg < sfvc_pkg::CNT_FRAME) begin
      unique case (eff_proto)
        sfvc_pkg::SFVC_PROTO_QUAD: in_sh_reg <= {in_sh_reg[11:0], dq_s2_reg};
        sfvc_pkg::SFVC_PROTO_DUAL: in_sh_reg <= {in_sh_reg[13:0], dq_s2_reg[1:0]};
        default: in_sh_reg <= {in_sh_reg[14:0], dq_s2_reg[0]};
      endcase
      cnt_reg <= cnt_reg + {2'b00, lanes};
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      op_reg <= 8'h00;
      op_valid_reg <= 1'b0;
    end else if (!selected) begin
      op_valid_reg <= 1'b0;
    end else if (cnt_reg == sfvc_pkg::CNT_OPCODE && !op_valid_reg) begin
      op_reg <= in_sh_reg[7:0];
      op_valid_reg <= 1'b1;
    end
  end

  // ****************************************
  // over-length frame guard
  // ****************************************
  // extra clocks past the data byte refuse the frame instead of committing it
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      frame_long_reg <= 1'b0;
    end else if (!selected) begin
      frame_long_reg <= 1'b0;
    end else if (sck_rise && cnt_reg == sfvc_pkg::CNT_FRAME) begin
      frame_long_reg <= 1'b1;
    end
  end

  // ****************************************
  // register read-back
  // ****************************************
  logic [7:0] out_sh_reg;
  logic rd_active_reg;
  logic rd_is_op;

  assign rd_is_op = is_read_op(in_sh_reg[7:0]);

  // data leaves on falling clock edges so the host samples it just before the next fall
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_sh_reg <= 8'h00;
      rd_active_reg <= 1'b0;
      dq_out <= 4'h0;
      dq_oe_out <= 4'h0;
    end else if (!selected) begin
      rd_active_reg <= 1'b0;
      dq_oe_out <= 4'h0;
    end else if (cnt_reg == sfvc_pkg::CNT_OPCODE && !op_valid_reg && rd_is_op) begin
      rd_active_reg <= 1'b1;
      out_sh_reg <= (in_sh_reg[7:0] == sfvc_pkg::OP_READ_READ_CFG) ? read_cfg_reg
                                                                   : enh_cfg_reg;
    end else if (sck_fall && rd_active_reg) begin
      unique case (eff_proto)
        sfvc_pkg::SFVC_PROTO_QUAD: begin
          dq_out <= out_sh_reg[7:4];
          dq_oe_out <= 4'hf;
          out_sh_reg <= {out_sh_reg[3:0], 4'h0};
        end
        sfvc_pkg::SFVC_PROTO_DUAL: begin
          dq_out <= {2'b00, out_sh_reg[7:6]};
          dq_oe_out <= 4'h3;
          out_sh_reg <= {out_sh_reg[5:0], 2'b00};
        end
        default: begin
          dq_out <= {2'b00, out_sh_reg[7], 1'b0};
          dq_oe_out <= 4'h2;
          out_sh_reg <= {out_sh_reg[6:0], 1'b0};
        end
      endcase
    end
  end

  // ****************************************
  // accelerating voltage sequencing
  // ****************************************
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_WAIT_VPP,
    ACC_BOOST
  } sfvc_acc_state_t;

  sfvc_acc_state_t acc_state_reg;
  logic [31:0] vpp_timer_reg;
  logic accel_applies;

  // the bit only matters for quad modify commands or quad protocol
  assign accel_applies = ~enh_cfg_reg[sfvc_pkg::EC_ACCEL_BIT] &
                         (quad_program_cmd_in |
                          (base_proto == sfvc_pkg::SFVC_PROTO_QUAD));

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_state_reg <= ACC_IDLE;
      vpp_timer_reg <= 32'h00000000;
      temp_ext_reg <= 1'b0;
      vpp_err_out <= 1'b0;
    end else begin
      vpp_err_out <= 1'b0;
      unique case (acc_state_reg)
        ACC_IDLE: begin
          if (quad_modify_done_in && accel_applies) begin
            acc_state_reg <= ACC_WAIT_VPP;
            vpp_timer_reg <= 32'h00000000;
            temp_ext_reg <= (base_proto == sfvc_pkg::SFVC_PROTO_QUAD);
          end
        end
        ACC_WAIT_VPP: begin
          if (vpp_s2_reg) begin
            acc_state_reg <= ACC_BOOST;
          end else if (vpp_timer_reg == 32'(VPP_TIMEOUT - 1)) begin
            // slow run: the voltage never came, so quad is back at once
            acc_state_reg <= ACC_IDLE;
            temp_ext_reg <= 1'b0;
            vpp_err_out <= 1'b1;
          end else begin
            vpp_timer_reg <= vpp_timer_reg + 32'h00000001;
          end
        end
        ACC_BOOST: begin
          if (!vpp_s2_reg) begin
            acc_state_reg <= ACC_IDLE;
            temp_ext_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  assign accel_speed_out = (acc_state_reg == ACC_BOOST);
  assign vpp_wait_out = (acc_state_reg == ACC_WAIT_VPP);

  // ****************************************
  // configuration outputs
  // ****************************************
  logic [3:0] dummy_raw;
  logic [2:0] drv_raw;

  assign dummy_raw = read_cfg_reg[sfvc_pkg::RC_DUMMY_MSB:sfvc_pkg::RC_DUMMY_LSB];
  assign drv_raw = enh_cfg_reg[sfvc_pkg::EC_DRV_MSB:sfvc_pkg::EC_DRV_LSB];

  always_comb begin
    // the host must pick a count that suits its clock; too few gives bad data
    cfg_out.dummy_cycles = (dummy_raw == sfvc_pkg::DUMMY_ZERO) ? sfvc_pkg::DUMMY_MAX
                                                               : dummy_raw;
    cfg_out.xip_ready = basic_xip_reg | ~read_cfg_reg[sfvc_pkg::RC_XIP_BIT];
    cfg_out.wrap = read_cfg_reg[sfvc_pkg::RC_WRAP_MSB:sfvc_pkg::RC_WRAP_LSB];
    cfg_out.proto = eff_proto;
    cfg_out.hold_en = enh_cfg_reg[sfvc_pkg::EC_HOLD_BIT];
    cfg_out.accel_en = ~enh_cfg_reg[sfvc_pkg::EC_ACCEL_BIT];
    cfg_out.drive = drv_raw;
    cfg_out.drive_reserved = (drv_raw == sfvc_pkg::DRV_RSVD_A) ||
                             (drv_raw == sfvc_pkg::DRV_RSVD_B);
  end

  // ****************************************
  // wrapping read address
  // ****************************************
  sfvc_wrap_addr u_wrap (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .load_in(rd_load_in),
    .start_addr_in(rd_start_addr_in),
    .advance_in(rd_advance_in),
    .wrap_in(cfg_out.wrap),
    .addr_out(rd_addr_out)
  );
endmodule : sfvc_config
`default_nettype wire

/* design/sfvc_pkg.sv */
// package: constants, types and field layout of the volatile configuration block
// Operation
// - dummy field sets fast read dummy cycles
// - xip bit must be cleared for xip
// - basic xip variants ignore the xip bit
// - wrap field applies to every read
// - wrap restarts at aligned block start
// - each register write replaces power-on values
// - quad bit low selects quad protocol
// - quad bit high resumes extended or dual
// - dual bit low selects dual, quad wins
// - hold bit low disables hold/reset pin
// - power-on restores hold unless nonvolatile disables
// - accel bit low enables high voltage
// - accel bit only for quad modify cases
// - accelerated quad modify temporarily uses extended
// - voltage timeout runs slow, flags error
// - drive code selects impedance, two reserved
// - dummy resets 15, zero acts as 15
// - wrap codes 16, 32, 64, sequential
`default_nettype none
package sfvc_pkg;
  // ****************************************
  // field layout
  // ****************************************
  localparam int RC_DUMMY_MSB = 7;
  localparam int RC_DUMMY_LSB = 4;
  localparam int RC_XIP_BIT = 3;
  localparam int RC_WRAP_MSB = 1;
  localparam int RC_WRAP_LSB = 0;
  localparam int EC_QUAD_BIT = 7;
  localparam int EC_DUAL_BIT = 6;
  localparam int EC_HOLD_BIT = 4;
  localparam int EC_ACCEL_BIT = 3;
  localparam int EC_DRV_MSB = 2;
  localparam int EC_DRV_LSB = 0;
  localparam logic [7:0] RC_WMASK = 8'hfb;
  localparam logic [7:0] EC_WMASK = 8'hdf;
  localparam logic [7:0] RC_RESET = 8'hfb;
  localparam logic [7:0] EC_RESET = 8'hdf;
  localparam logic [3:0] DUMMY_ZERO = 4'h0;
  localparam logic [3:0] DUMMY_MAX = 4'hf;
  localparam logic [2:0] DRV_RSVD_A = 3'h0;
  localparam logic [2:0] DRV_RSVD_B = 3'h4;
  localparam logic [1:0] WRAP_16 = 2'h0;
  localparam logic [1:0] WRAP_32 = 2'h1;
  localparam logic [1:0] WRAP_64 = 2'h2;
  localparam logic [1:0] WRAP_SEQ = 2'h3;
  // ****************************************
  // serial commands
  // ****************************************
  localparam logic [7:0] OP_WRITE_READ_CFG = 8'ha1;
  localparam logic [7:0] OP_WRITE_ENH_CFG = 8'ha2;
  localparam logic [7:0] OP_READ_READ_CFG = 8'ha3;
  localparam logic [7:0] OP_READ_ENH_CFG = 8'ha4;
  localparam logic [4:0] CNT_OPCODE = 5'h08;
  localparam logic [4:0] CNT_FRAME = 5'h10;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int VPP_TIMEOUT_MS = 200;
  localparam int VPP_TIMEOUT_CYC = VPP_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int ADDR_W = 24;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SFVC_PROTO_EXT,
    SFVC_PROTO_DUAL,
    SFVC_PROTO_QUAD
  } sfvc_proto_t;
  typedef struct packed {
    logic [3:0] dummy_cycles;
    logic xip_ready;
    logic [1:0] wrap;
    sfvc_proto_t proto;
    logic hold_en;
    logic accel_en;
    logic [2:0] drive;
    logic drive_reserved;
  } sfvc_cfg_t;
endpackage : sfvc_pkg
`default_nettype wire

/* design/sfvc_wrap_addr.sv */
// read address counter that wraps inside an aligned block
`timescale 1ns/1ps
`default_nettype none
module sfvc_wrap_addr (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [sfvc_pkg::ADDR_W-1:0] start_addr_in,
  input wire logic advance_in,
  input wire logic [1:0] wrap_in,
  output logic [sfvc_pkg::ADDR_W-1:0] addr_out
);
  logic [sfvc_pkg::ADDR_W-1:0] mask;
  logic [sfvc_pkg::ADDR_W-1:0] inc;
  logic [sfvc_pkg::ADDR_W-1:0] addr_next;

  always_comb begin
    unique case (wrap_in)
      sfvc_pkg::WRAP_16: mask = 24'h00000f;
      sfvc_pkg::WRAP_32: mask = 24'h00001f;
      sfvc_pkg::WRAP_64: mask = 24'h00003f;
      default: mask = 24'hffffff;
    endcase
    inc = addr_out + 24'h000001;
    // high bits stay fixed, so the count returns to the block start
    addr_next = (addr_out & ~mask) | (inc & mask);
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_out <= 24'h000000;
    end else if (load_in) begin
      addr_out <= start_addr_in;
    end else if (advance_in) begin
      addr_out <= addr_next;
    end
  end
endmodule : sfvc_wrap_addr
`default_nettype wire

/* dv/sfvc_config_chk.sv */
// checker: port-level assertions for the volatile configuration block
`timescale 1ns/1ps
`default_nettype none
module sfvc_config_chk #(
  parameter int VPP_TIMEOUT = sfvc_pkg::VPP_TIMEOUT_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic vpp_high_in,
  input wire logic quad_modify_done_in,
  input wire logic quad_program_cmd_in,
  input wire logic rd_load_in,
  input wire logic [sfvc_pkg::ADDR_W-1:0] rd_start_addr_in,
  input wire logic rd_advance_in,
  input wire logic [sfvc_pkg::ADDR_W-1:0] rd_addr_out,
  input wire sfvc_pkg::sfvc_cfg_t cfg_out,
  input wire logic accel_speed_out,
  input wire logic vpp_wait_out,
  input wire logic vpp_err_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic idle;
  int wait_cnt;
  assign idle = !vpp_wait_out && !accel_speed_out;
  // counts the wait so a stuck wait is caught without a long repetition
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_cnt <= 0;
    end else begin
      wait_cnt <= vpp_wait_out ? wait_cnt + 1 : 0;
    end
  end
  sequence s_step;
    rd_advance_in && !rd_load_in;
  endsequence
  sequence s_accel_req;
    idle && quad_modify_done_in && cfg_out.accel_en &&
      (quad_program_cmd_in || cfg_out.proto == sfvc_pkg::SFVC_PROTO_QUAD);
  endsequence
  a_dummy_never_zero: assert property (cfg_out.dummy_cycles != 4'h0)
    else $error("dummy count shows zero");
  a_drive_rsvd_flag: assert property (cfg_out.drive_reserved ==
    (cfg_out.drive == sfvc_pkg::DRV_RSVD_A || cfg_out.drive == sfvc_pkg::DRV_RSVD_B))
    else $error("drive reserved flag wrong");
  a_load_addr: assert property (rd_load_in |=> rd_addr_out == $past(rd_start_addr_in))
    else $error("address load wrong");
  a_wrap_sixteen: assert property (s_step ##0 cfg_out.wrap == sfvc_pkg::WRAP_16 |=>
    rd_addr_out == {$past(rd_addr_out[23:4]), $past(rd_addr_out[3:0]) + 4'h1})
    else $error("16 byte wrap step wrong");
  a_wrap_thirtytwo: assert property (s_step ##0 cfg_out.wrap == sfvc_pkg::WRAP_32 |=>
    rd_addr_out == {$past(rd_addr_out[23:5]), $past(rd_addr_out[4:0]) + 5'h01})
    else $error("32 byte wrap step wrong");
  a_seq_step: assert property (s_step ##0 cfg_out.wrap == sfvc_pkg::WRAP_SEQ |=>
    rd_addr_out == $past(rd_addr_out) + 24'h000001)
    else $error("sequential step wrong");
  a_accel_start: assert property (s_accel_req |=> vpp_wait_out)
    else $error("accelerated modify did not wait for voltage");
  a_accel_ignored: assert property (idle && quad_modify_done_in && !cfg_out.accel_en
    |=> !vpp_wait_out)
    else $error("voltage wait without accelerator enable");
  a_temp_extended: assert property (!idle |-> cfg_out.proto != sfvc_pkg::SFVC_PROTO_QUAD)
    else $error("quad protocol during accelerated modify");
  a_boost_on_vpp: assert property (vpp_wait_out && vpp_high_in |->
    ##[1:4] (accel_speed_out || vpp_err_out))
    else $error("voltage present but no boost");
  a_err_after_wait: assert property ($rose(vpp_err_out) |-> $past(vpp_wait_out) ##1 !vpp_err_out)
    else $error("voltage error without wait or not a pulse");
  a_wait_bounded: assert property (wait_cnt <= VPP_TIMEOUT + 2)
    else $error("voltage wait outlived the timeout");
endmodule : sfvc_config_chk
bind sfvc_config sfvc_config_chk #(.VPP_TIMEOUT(VPP_TIMEOUT)) u_sfvc_config_chk (.*);
`default_nettype wire

/* dv/sfvc_host.sv */
// partner: host serial controller making frames on the link pins
`timescale 1ns/1ps
`default_nettype none
module sfvc_host (
  input wire logic sys_clk_in,
  input wire logic [3:0] dev_dq_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic [3:0] dq_out
);
  // link clock stands low outside frames; released lines flip so no stale value survives
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    dq_out = 4'h5;
  end
  // fixed 200 ns link clock: the dummy count it needs is the host's choice
  task automatic xfer(input logic [7:0] op, input logic [7:0] wd, input int lanes,
      input bit rd, output logic [7:0] rdat);
    logic [15:0] sh;
    int n;
    sh = {op, wd};
    n = rd ? 8 : 16;
    rdat = 8'h00;
    @(negedge sys_clk_in);
    #7;
    cs_n_out = 1'b0;
    for (int i = 0; i < n; i += lanes) begin
      dq_out = sh[15:12] >> (4 - lanes);
      sh = sh << lanes;
      #100 sck_out = 1'b1;
      #100 sck_out = 1'b0;
    end
    for (int i = 0; rd && i < 8; i += lanes) begin
      dq_out = ~dq_out;
      #100 sck_out = 1'b1;
      // sampled just before the fall, while the device still holds the bits
      #100;
      case (lanes)
        4: rdat = {rdat[3:0], dev_dq_in};
        2: rdat = {rdat[5:0], dev_dq_in[1:0]};
        default: rdat = {rdat[6:0], dev_dq_in[1]};
      endcase
      sck_out = 1'b0;
    end
    #100 cs_n_out = 1'b1;
    dq_out = ~dq_out;
    repeat (10) @(negedge sys_clk_in);
  endtask : xfer
endmodule : sfvc_host
`default_nettype wire

/* dv/testbench.sv */
// testbench: register writes, reads, wrap stepping and accelerator paths
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] WRC = sfvc_pkg::OP_WRITE_READ_CFG;
  localparam logic [7:0] WEC = sfvc_pkg::OP_WRITE_ENH_CFG;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic strap = 1'b0, vpp = 1'b0, done = 1'b0, qprog = 1'b0, load = 1'b0, adv = 1'b0;
  logic sck, cs_n, spd, wt, err;
  logic [3:0] h_dq, d_dq, d_oe, dq_in;
  logic [7:0] nvr = 8'h0d, nve = 8'he7;
  logic [23:0] start = 24'h0, addr, e;
  sfvc_pkg::sfvc_cfg_t cfg;
  int error_cnt = 0;
  int num_checks = 0;
  logic [7:0] pv [5] = '{8'hcf, 8'h9f, 8'h1f, 8'h9f, 8'hdf};
  int ln [5] = '{1, 1, 2, 4, 2};
  logic [1:0] pe [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h0};
  always #12.5 sys_clk_in = ~sys_clk_in;
  assign dq_in = (d_oe & d_dq) | (~d_oe & h_dq);
  sfvc_config #(.VPP_TIMEOUT(50)) u_sfvc_config (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .sck_in(sck), .cs_n_in(cs_n), .dq_in(dq_in), .dq_out(d_dq), .dq_oe_out(d_oe),
    .nv_read_config_in(nvr), .nv_enhanced_config_in(nve), .basic_xip_variant_in(strap),
    .vpp_high_in(vpp), .quad_modify_done_in(done), .quad_program_cmd_in(qprog),
    .rd_load_in(load), .rd_start_addr_in(start), .rd_advance_in(adv), .rd_addr_out(addr),
    .cfg_out(cfg), .accel_speed_out(spd), .vpp_wait_out(wt), .vpp_err_out(err));
  sfvc_host u_sfvc_host (.sys_clk_in(sys_clk_in), .dev_dq_in(dq_in), .sck_out(sck),
    .cs_n_out(cs_n), .dq_out(h_dq));
  // ****************************************
  // tasks
  // ****************************************
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] op, input logic [7:0] d, input int l);
    logic [7:0] x;
    u_sfvc_host.xfer(op, d, l, 1'b0, x);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] op, input logic [7:0] exp, input int l);
    logic [7:0] x;
    u_sfvc_host.xfer(op, 8'h00, l, 1'b1, x);
    chk(nm, exp, x);
    chk("oe_off", 32'h0, d_oe);
  endtask : rdc
  task automatic wait_for(input string nm, ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < 200) begin
      @(negedge sys_clk_in);
      k++;
    end
    chk(nm, v, s);
    if (s !== v) begin
      close_out();
    end
  endtask : wait_for
  task automatic pulse(ref logic s);
    @(negedge sys_clk_in);
    s = 1'b1;
    @(negedge sys_clk_in);
    s = 1'b0;
    @(negedge sys_clk_in);
  endtask : pulse
  function automatic logic [23:0] nxt(input logic [23:0] a, input logic [1:0] w);
    logic [23:0] m;
    m = (24'h000010 << w) - 24'h000001;
    return (w == 2'h3) ? a + 24'h000001 : (a & ~m) | ((a + 24'h000001) & m);
  endfunction : nxt
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(negedge sys_clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    chk("dummy", 4'hf, cfg.dummy_cycles);
    chk("wrap", 2'h1, cfg.wrap);
    chk("hold", 1'b0, cfg.hold_en);
    chk("xip", 1'b0, cfg.xip_ready);
    rdc("enh_rb", sfvc_pkg::OP_READ_ENH_CFG, 8'hc7, 1);
    rdc("rd_rb", sfvc_pkg::OP_READ_READ_CFG, 8'h09, 1);
    $display("test power_on done");
    wr(WRC, 8'h07, 1);
    chk("dummy", 4'hf, cfg.dummy_cycles);
    chk("xip", 1'b1, cfg.xip_ready);
    for (int w = 0; w < 4; w++) begin
      wr(WRC, {6'h17, w[1:0]}, 1);
      chk("dummy", 4'h5, cfg.dummy_cycles);
      chk("wrap", w[1:0], cfg.wrap);
      rdc("rd_rb", sfvc_pkg::OP_READ_READ_CFG, {6'h16, w[1:0]}, 1);
      start = 24'h12340f;
      pulse(load);
      e = start;
      chk("addr", e, addr);
      for (int i = 0; i < 17; i++) begin
        pulse(adv);
        e = nxt(e, w[1:0]);
        chk("addr", e, addr);
      end
    end
    $display("test read_config done");
    for (int i = 0; i < 5; i++) begin
      wr(WEC, pv[i], ln[i]);
      chk("proto", pe[i], cfg.proto);
      chk("hold", i != 0, cfg.hold_en);
      rdc("enh_rb", sfvc_pkg::OP_READ_ENH_CFG, pv[i], 1 << pe[i]);
    end
    for (int d = 0; d < 8; d++) begin
      wr(WEC, {5'h1b, d[2:0]}, 1);
      chk("drive", d[2:0], cfg.drive);
      chk("drv_rsvd", d == 0 || d == 4, cfg.drive_reserved);
    end
    $display("test enhanced_config done");
    wr(WEC, 8'h17, 1);
    chk("accel", 1'b1, cfg.accel_en);
    pulse(done);
    chk("wait", 1'b1, wt);
    chk("proto", 2'h0, cfg.proto);
    vpp = 1'b1;
    wait_for("boost", spd, 1'b1);
    chk("proto", 2'h0, cfg.proto);
    vpp = 1'b0;
    wait_for("boost", spd, 1'b0);
    repeat (3) @(negedge sys_clk_in);
    chk("proto", 2'h2, cfg.proto);
    pulse(done);
    wait_for("vpp_err", err, 1'b1);
    @(negedge sys_clk_in);
    chk("wait", 1'b0, wt);
    wr(WEC, 8'hdf, 4);
    qprog = 1'b1;
    pulse(done);
    chk("wait", 1'b0, wt);
    wr(WEC, 8'hd7, 1);
    pulse(done);
    chk("wait", 1'b1, wt);
    wait_for("vpp_err", err, 1'b1);
    qprog = 1'b0;
    $display("test accelerator done");
    rst_in = 1'b1;
    strap = 1'b1;
    nvr = 8'hfb;
    repeat (8) @(negedge sys_clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    chk("xip", 1'b1, cfg.xip_ready);
    $display("test basic_xip done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
